// ### logic/dcc_chan_if.sv
// Register access carrier between the top level and one comparator channel.
interface dcc_chan_if;
   logic       wr_ctl;
   logic       wr_mode;
   logic [7:0] wdata;
   logic [7:0] ctl_rdata;
   logic [7:0] mode_rdata;
   logic       irq;

   modport host (output wr_ctl, output wr_mode, output wdata,
                 input ctl_rdata, input mode_rdata, input irq);
   modport chan (input wr_ctl, input wr_mode, input wdata,
                 output ctl_rdata, output mode_rdata, output irq);
endinterface

// ### logic/dcc_channel.sv
// One comparator channel: control and mode registers, edge flags and analog core controls.
module dcc_channel #(
   parameter int unsigned SYNC_STAGES = 2
) (
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_resetn,
   // Register access
   dcc_chan_if.chan        bus,
   // Analog core
   input  wire logic       i_cmp_raw,
   output logic            o_enable,
   output logic [1:0]      o_pos_hyst_select,
   output logic [1:0]      o_neg_hyst_select,
   output logic [1:0]      o_response_mode_select,
   output logic            o_compare_result
);
   // A single stage would let the edge detector read a possibly metastable flop.
   if (SYNC_STAGES < 2) begin : g_bad_sync_stages
      $error("SYNC_STAGES must be at least 2");
   end

   typedef struct packed {
      logic [SYNC_STAGES-1:0] sync;
      logic                   prev;
      logic                   channel_enable;
      logic                   rise_flag;
      logic                   fall_flag;
      logic [1:0]             pos_hyst_select;
      logic [1:0]             neg_hyst_select;
      logic                   rise_irq_enable;
      logic                   fall_irq_enable;
      logic [1:0]             response_mode_select;
      logic                   out_gated;
   } dcc_chan_state_t;

   dcc_chan_state_t s_q;
   dcc_chan_state_t s_d;
   logic            result;
   logic            rise_ev;
   logic            fall_ev;

   // Only the last synchroniser stage is looked at; the first stage may be metastable.
   assign result  = s_q.sync[SYNC_STAGES-1];
   assign rise_ev = result & ~s_q.prev;
   assign fall_ev = ~result & s_q.prev;

   always_comb begin
      s_d      = s_q;
      s_d.sync = {s_q.sync[SYNC_STAGES-2:0], i_cmp_raw};
      s_d.prev = result;
      if (bus.wr_ctl) begin
         s_d.channel_enable  = bus.wdata[dcc_pkg::CTL_ENABLE_BIT];
         s_d.rise_flag       = bus.wdata[dcc_pkg::CTL_RISE_BIT];
         s_d.fall_flag       = bus.wdata[dcc_pkg::CTL_FALL_BIT];
         s_d.pos_hyst_select = bus.wdata[dcc_pkg::CTL_HYP_LSB +: 2];
         s_d.neg_hyst_select = bus.wdata[dcc_pkg::CTL_HYN_LSB +: 2];
      end
      if (bus.wr_mode) begin
         s_d.rise_irq_enable      = bus.wdata[dcc_pkg::MODE_RIE_BIT];
         s_d.fall_irq_enable      = bus.wdata[dcc_pkg::MODE_FIE_BIT];
         s_d.response_mode_select = bus.wdata[dcc_pkg::MODE_SEL_LSB +: 2];
      end
      // An edge in the cycle of a software clear still lands, so no event is lost.
      s_d.rise_flag = s_d.rise_flag | rise_ev;
      s_d.fall_flag = s_d.fall_flag | fall_ev;
      s_d.out_gated = s_q.channel_enable & result;
      if (!i_resetn) begin
         s_d                      = '0;
         s_d.channel_enable       = dcc_pkg::CONTROL_RESET[dcc_pkg::CTL_ENABLE_BIT];
         s_d.pos_hyst_select      = dcc_pkg::CONTROL_RESET[dcc_pkg::CTL_HYP_LSB +: 2];
         s_d.neg_hyst_select      = dcc_pkg::CONTROL_RESET[dcc_pkg::CTL_HYN_LSB +: 2];
         s_d.rise_irq_enable      = dcc_pkg::MODE_RESET[dcc_pkg::MODE_RIE_BIT];
         s_d.fall_irq_enable      = dcc_pkg::MODE_RESET[dcc_pkg::MODE_FIE_BIT];
         s_d.response_mode_select = dcc_pkg::MODE_RESET[dcc_pkg::MODE_SEL_LSB +: 2];
      end
   end

   always_ff @(posedge i_core_clk) begin
      s_q <= s_d;
   end

   assign bus.ctl_rdata  = {s_q.channel_enable, result, s_q.rise_flag, s_q.fall_flag,
                            s_q.pos_hyst_select, s_q.neg_hyst_select};
   assign bus.mode_rdata = {2'h0, s_q.rise_irq_enable, s_q.fall_irq_enable,
                            2'h0, s_q.response_mode_select};
   assign bus.irq        = (s_q.rise_flag & s_q.rise_irq_enable)
                         | (s_q.fall_flag & s_q.fall_irq_enable);

   assign o_enable               = s_q.channel_enable;
   assign o_pos_hyst_select      = s_q.pos_hyst_select;
   assign o_neg_hyst_select      = s_q.neg_hyst_select;
   assign o_response_mode_select = s_q.response_mode_select;
   assign o_compare_result       = s_q.out_gated;
endmodule

// ### logic/dcc_pkg.sv
// Shared addresses, field positions and reset values of the dual comparator control block.
package dcc_pkg;
   localparam logic [7:0] ADDR_B_CONTROL = 8'h9A;
   localparam logic [7:0] ADDR_A_CONTROL = 8'h9B;
   localparam logic [7:0] ADDR_B_MODE    = 8'h9C;
   localparam logic [7:0] ADDR_A_MODE    = 8'h9D;

   localparam int unsigned CTL_ENABLE_BIT = 7;
   localparam int unsigned CTL_RESULT_BIT = 6;
   localparam int unsigned CTL_RISE_BIT   = 5;
   localparam int unsigned CTL_FALL_BIT   = 4;
   localparam int unsigned CTL_HYP_LSB    = 2;
   localparam int unsigned CTL_HYN_LSB    = 0;
   localparam int unsigned MODE_RIE_BIT   = 5;
   localparam int unsigned MODE_FIE_BIT   = 4;
   localparam int unsigned MODE_SEL_LSB   = 0;

   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic [7:0] MODE_RESET     = 8'h02;
   localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
endpackage

// ### logic/dcc_top.sv
// Dual comparator control: special-function-register decode and two comparator channels.
// Operation
// - Two identical channels, each with control register.
// - Falling output edge sets the fall flag.
// - Rising output edge sets the rise flag.
// - Edge flags stay set until software clears.
// - Rise flag interrupts only when rise enabled.
// - Fall flag interrupts only when fall enabled.
// - Control bit 6 reads output; writes ignored.
// - Control bit 7 enables the analog comparator.
// - Control bits 3:2 select positive hysteresis.
// - Control bits 1:0 select negative hysteresis.
// - Mode bits 1:0 select response speed.
// - Unused mode bits read zero, ignore writes.
// - Disabled channel presents a low output.
module dcc_top #(
   parameter int unsigned SYNC_STAGES = 2
) (
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_resetn,
   // Special-function-register bus
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_wr,
   input  wire logic [7:0] i_sfr_wdata,
   output logic [7:0]      o_sfr_rdata,
   // Analog comparator cores, index is the channel number
   input  wire logic [1:0] i_cmp_raw,
   output logic [1:0]      o_channel_enable,
   output logic [3:0]      o_pos_hyst_select,
   output logic [3:0]      o_neg_hyst_select,
   output logic [3:0]      o_response_mode_select,
   output logic [1:0]      o_compare_result,
   // Interrupt requests to the interrupt controller
   output logic [1:0]      o_irq
);
   typedef struct packed {
      logic [7:0] rdata;
   } dcc_top_state_t;

   localparam logic [7:0] CTL_ADDR  [2] = '{dcc_pkg::ADDR_A_CONTROL, dcc_pkg::ADDR_B_CONTROL};
   localparam logic [7:0] MODE_ADDR [2] = '{dcc_pkg::ADDR_A_MODE, dcc_pkg::ADDR_B_MODE};

   dcc_top_state_t s_q;
   dcc_top_state_t s_d;
   logic [7:0]     ctl_rd  [2];
   logic [7:0]     mode_rd [2];

   dcc_chan_if ch_if [2] ();

   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign ch_if[g].wr_ctl  = i_sfr_wr && (i_sfr_addr == CTL_ADDR[g]);
      assign ch_if[g].wr_mode = i_sfr_wr && (i_sfr_addr == MODE_ADDR[g]);
      assign ch_if[g].wdata   = i_sfr_wdata;
      assign ctl_rd[g]        = ch_if[g].ctl_rdata;
      assign mode_rd[g]       = ch_if[g].mode_rdata;
      assign o_irq[g]         = ch_if[g].irq;

      dcc_channel #(
         .SYNC_STAGES (SYNC_STAGES)
      ) u_chan (
         .i_core_clk             (i_core_clk),
         .i_resetn               (i_resetn),
         .bus                    (ch_if[g]),
         .i_cmp_raw              (i_cmp_raw[g]),
         .o_enable               (o_channel_enable[g]),
         .o_pos_hyst_select      (o_pos_hyst_select[2*g +: 2]),
         .o_neg_hyst_select      (o_neg_hyst_select[2*g +: 2]),
         .o_response_mode_select (o_response_mode_select[2*g +: 2]),
         .o_compare_result       (o_compare_result[g])
      );
   end

   // Read data is registered, so software sees it one clock after presenting the address.
   always_comb begin
      s_d.rdata = dcc_pkg::UNMAPPED_VALUE;
      case (i_sfr_addr)
         dcc_pkg::ADDR_A_CONTROL: s_d.rdata = ctl_rd[0];
         dcc_pkg::ADDR_B_CONTROL: s_d.rdata = ctl_rd[1];
         dcc_pkg::ADDR_A_MODE:    s_d.rdata = mode_rd[0];
         dcc_pkg::ADDR_B_MODE:    s_d.rdata = mode_rd[1];
         default:                 s_d.rdata = dcc_pkg::UNMAPPED_VALUE;
      endcase
      if (!i_resetn) begin
         s_d.rdata = dcc_pkg::UNMAPPED_VALUE;
      end
   end

   always_ff @(posedge i_core_clk) begin
      s_q <= s_d;
   end

   assign o_sfr_rdata = s_q.rdata;
endmodule

// ### verification/dcc_cmp_model.sv
// Behavioural pair of analog comparator cores.
module dcc_cmp_model (
   // Enables from the block, input polarity from the bench
   input  wire logic [1:0] i_channel_enable,
   input  wire logic [1:0] i_level,
   output logic [1:0]      o_cmp_raw
);
   timeunit 1ns / 1ns;
   // An unpowered core drives low rather than keeping its last decision.
   assign o_cmp_raw = i_channel_enable & i_level;
endmodule

// ### verification/dcc_top_sva.sv
// Port checker of the comparator control block.
module dcc_top_sva (
   // Top ports
   input wire logic       i_core_clk,
   input wire logic       i_resetn,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic [1:0] o_channel_enable,
   input wire logic [3:0] o_pos_hyst_select,
   input wire logic [3:0] o_neg_hyst_select,
   input wire logic [3:0] o_response_mode_select,
   input wire logic [1:0] o_compare_result,
   input wire logic [1:0] o_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   wire wa = i_sfr_wr && i_sfr_addr == 8'h9B;
   wire wm = i_sfr_wr && i_sfr_addr == 8'h9D;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   property p_en_a; wa |=> o_channel_enable[0] == $past(i_sfr_wdata[7]); endproperty
   a_en_a: assert property (p_en_a) else $error("en0");
   property p_en_b; i_sfr_wr && i_sfr_addr == 8'h9A |=> o_channel_enable[1] == $past(i_sfr_wdata[7]); endproperty
   a_en_b: assert property (p_en_b) else $error("en1");
   property p_hyp; wa |=> o_pos_hyst_select[1:0] == $past(i_sfr_wdata[3:2]); endproperty
   a_hyp: assert property (p_hyp) else $error("hyp");
   property p_hyn; wa |=> o_neg_hyst_select[1:0] == $past(i_sfr_wdata[1:0]); endproperty
   a_hyn: assert property (p_hyn) else $error("hyn");
   property p_mode; wm |=> o_response_mode_select[1:0] == $past(i_sfr_wdata[1:0]); endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_irq; wm && i_sfr_wdata[5:4] == 2'b00 |=> !o_irq[0]; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_low; !$past(o_channel_enable[0]) && !o_channel_enable[0] |-> !o_compare_result[0]; endproperty
   a_low: assert property (p_low) else $error("low");
   property p_zero; ($past(i_sfr_addr) | 8'h01) == 8'h9D |-> (o_sfr_rdata & 8'hCC) == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("zero");
   property p_keep; $past(i_sfr_addr) == 8'h9B && i_sfr_addr == 8'h9B && !$past(i_sfr_wr) && !i_sfr_wr
      && o_sfr_rdata[5] |=> o_sfr_rdata[5]; endproperty
   a_keep: assert property (p_keep) else $error("keep");
endmodule
bind dcc_top dcc_top_sva dcc_top_sva_inst (
   .i_core_clk             (i_core_clk),
   .i_resetn               (i_resetn),
   .i_sfr_addr             (i_sfr_addr),
   .i_sfr_wr               (i_sfr_wr),
   .i_sfr_wdata            (i_sfr_wdata),
   .o_sfr_rdata            (o_sfr_rdata),
   .o_channel_enable       (o_channel_enable),
   .o_pos_hyst_select      (o_pos_hyst_select),
   .o_neg_hyst_select      (o_neg_hyst_select),
   .o_response_mode_select (o_response_mode_select),
   .o_compare_result       (o_compare_result),
   .o_irq                  (o_irq)
);

// ### verification/dcc_top_tb_top.sv
// Self-checking bench of the comparator control block.
module dcc_top_tb_top;
   timeunit 1ns / 1ns;
   logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rd;
   logic [1:0] lvl = 2'b00, raw, en, res, irq;
   logic [3:0] hp, hn, md;
   int         errors = 0, comparisons = 0;
   always #25 clk = ~clk;
   dcc_top dcc_top_inst (.i_core_clk(clk), .i_resetn(rstn), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wd),
      .o_sfr_rdata(rd), .i_cmp_raw(raw), .o_channel_enable(en), .o_pos_hyst_select(hp), .o_neg_hyst_select(hn),
      .o_response_mode_select(md), .o_compare_result(res), .o_irq(irq));
   dcc_cmp_model dcc_cmp_model_inst (.i_channel_enable(en), .i_level(lvl), .o_cmp_raw(raw));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      errors += int'(g !== e);
      if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      // One idle edge keeps back-to-back writes from toggling the strobe in one time step.
      @(negedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      repeat (4) @(negedge clk);
      chk(rd, e);
   endtask
   task automatic end_sim;
      $display("%0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000 errors++;
      end_sim;
   end
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      rdc(8'h9D, 8'h02);
      rdc(8'h9C, 8'h02);
      rdc(8'h9E, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wrt(8'h9B, 8'h80 | 8'(c * 5));
         wrt(8'h9A, 8'h80 | 8'(c * 5));
         wrt(8'h9D, 8'hCC | 8'(c));
         wrt(8'h9C, 8'hCC | 8'(3 - c));
         chk({hp, hn}, {4{2'(c)}});
         chk(8'({md, en}), 8'({2'(3 - c), 2'(c), 2'b11}));
      end
      rdc(8'h9D, 8'h03);
      rdc(8'h9C, 8'h00);
      $display("test 1 done");
      wrt(8'h9D, 8'h20);
      lvl = 2'b11;
      rdc(8'h9B, 8'hEF);
      chk(8'({res, irq}), 8'h0D);
      lvl = 2'b00;
      rdc(8'h9B, 8'hBF);
      wrt(8'h9D, 8'h10);
      chk(8'(irq), 8'h01);
      wrt(8'h9D, 8'h00);
      chk(8'(irq), 8'h00);
      rdc(8'h9A, 8'hBF);
      $display("test 2 done");
      wrt(8'h9B, 8'h8F);
      wrt(8'h9A, 8'h80);
      rdc(8'h9B, 8'h8F);
      rdc(8'h9A, 8'h80);
      wrt(8'h9A, 8'hF0);
      rdc(8'h9A, 8'hB0);
      // The clear below is taken at the very edge at which the rising edge is flagged.
      lvl = 2'b01;
      repeat (2) @(negedge clk);
      wrt(8'h9B, 8'h8F);
      rdc(8'h9B, 8'hEF);
      lvl = 2'b11;
      rdc(8'h9A, 8'hF0);
      chk(8'(res), 8'h03);
      wrt(8'h9A, 8'h30);
      chk(8'({res, en}), 8'h05);
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      rdc(8'h9B, 8'h00);
      chk(8'({en, md}), 8'h0A);
      $display("test 3 done");
      end_sim;
   end
endmodule
